// *** src/ufb_defs.svh ***
/*
  Register indices, field positions, reset values and timing figures
  for the serial frame and baud configuration block.
  Assumes inclusion by bare name from the design file.
*/
`ifndef UFB_DEFS_SVH
`define UFB_DEFS_SVH
// Register indices; the byte address is four times the index
`define UFB_IDX_RX_LOW 8'h00
`define UFB_IDX_RX_HIGH 8'h01
`define UFB_IDX_TX_LOW 8'h02
`define UFB_IDX_TX_HIGH 8'h03
`define UFB_IDX_STATUS 8'h04
`define UFB_IDX_CTRLB 8'h06
`define UFB_IDX_FRAME 8'h07
`define UFB_IDX_BAUD_LOW 8'h08
`define UFB_IDX_BAUD_HIGH 8'h09
`define UFB_IDX_WINDOW 8'h0a
// Field positions
`define UFB_MODE_HI 7
`define UFB_MODE_LO 6
`define UFB_PAR_HI 5
`define UFB_PAR_LO 4
`define UFB_STOP_BIT 3
`define UFB_SIZE_HI 2
`define UFB_SIZE_LO 0
`define UFB_ORDER_BIT 2
`define UFB_PHASE_BIT 1
`define UFB_MULTI_NODE_ADDRESS_ENABLE_BIT 0
`define UFB_RXM_HI 2
`define UFB_RXM_LO 1
`define UFB_WIN_HI 7
`define UFB_WIN_LO 6
`define UFB_SYNC_ERR_BIT 0
// Reset values
`define UFB_FRAME_RST 8'h03
`define UFB_CTRLB_RST 8'h00
`define UFB_WINDOW_RST 8'h00
`define UFB_BAUD_RST 16'h0000
// Auto-baud figures
`define UFB_SYNC_CHAR 8'h55
`define UFB_NOMINAL_GAP 6'h20
`define UFB_SAMPLES_PER_BIT 5'h10
`define UFB_TOL_W0 6'h06
`define UFB_TOL_W1 6'h05
`define UFB_TOL_W2 6'h07
`define UFB_TOL_W3 6'h08
`endif

// *** src/ufb_pkg.sv ***
/*
  Types shared by the frame and baud configuration block.
  Assumes nothing of its surroundings.
*/
package ufb_pkg;
  typedef enum logic [1:0] {
    UFB_ASYNC = 2'b00,
    UFB_SYNC = 2'b01,
    UFB_INFRARED = 2'b10,
    UFB_HOST_SPI = 2'b11
  } ufb_link_mode_t;
  typedef enum logic [1:0] {
    UFB_PAR_NONE = 2'b00,
    UFB_PAR_RSVD = 2'b01,
    UFB_PAR_EVEN = 2'b10,
    UFB_PAR_ODD = 2'b11
  } ufb_parity_t;
  typedef enum logic [2:0] {
    UFB_CH5 = 3'b000,
    UFB_CH6 = 3'b001,
    UFB_CH7 = 3'b010,
    UFB_CH8 = 3'b011,
    UFB_CH_R4 = 3'b100,
    UFB_CH_R5 = 3'b101,
    UFB_CH9_LOW = 3'b110,
    UFB_CH9_HIGH = 3'b111
  } ufb_char_size_t;
  typedef enum logic [1:0] {
    UFB_RX_NORMAL = 2'b00,
    UFB_RX_DOUBLE = 2'b01,
    UFB_RX_GEN_AUTO = 2'b10,
    UFB_RX_LIN_AUTO = 2'b11
  } ufb_rx_speed_t;
endpackage

// *** src/ufb_config.sv ***
/*
  Frame, mode and baud configuration registers of a serial transceiver,
  an AXI4-Lite slave, plus the transmit word FIFO that feeds the shifter.
  Assumes the shifter, sampler and auto-baud engines sit outside on aclk.
*/
// Overview of operation
// R1: Multi-node address enable bit switches multi-processor mode on at 1, off at 0.
// R2: Link mode field: 0 async, 1 sync, 2 infrared, 3 host SPI.
// R3: In host SPI mode the low frame bits become bit order and sample phase.
// R4: Parity field: 0 none, 2 even, 3 odd; 1 is reserved.
// R5: Stop count bit gives one or two transmitted stop bits; receiver ignores it.
// R6: Shared char width: codes 0-3 give 5-8 bits, 6 and 7 give 9.
// R7: Nine-bit words: code 6 takes low byte first, code 7 high byte first.
// R8: SPI bit order 0 shifts MSB first, 1 LSB first, both directions.
// R9: Software must not change SPI bit order during a transfer.
// R10: SPI sample phase 0 samples on leading edge, 1 on trailing edge.
// R11: Baud divisor is 16 bits: low byte at base, high byte next.
// R12: Any baud divisor write reloads the prescaler at once.
// R13: Software should not change the baud divisor while transferring.
// R14: LIN auto-baud nominal gap is 32 samples, 16 samples per bit.
// R15: Window field gives 32 plus or minus 6, 5, 7, 8 for codes 0-3.
// R16: Receiver speed code 3 selects LIN auto-baud, where the window applies.
// R17: In LIN auto-baud a sync character other than 0x55 flags an error.
// R18: Software never writes reserved parity or width codes.
// R19: Reset gives async, no parity, one stop, eight bits, zero baud and window.
`timescale 1ns/1ps
`include "ufb_defs.svh"
`default_nettype none

module ufb_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  logic push;
  logic pop;
  assign in_ready = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem_q[rd_q];
  always_ff @(posedge aclk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

module ufb_config #(
  parameter int FIFO_DEPTH = 16
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Mode and frame format to the engines
  output ufb_pkg::ufb_link_mode_t link_mode_select,
  output logic infrared_mode,
  output logic host_spi_mode,
  output logic multi_node_address_enable,
  output ufb_pkg::ufb_parity_t parity_select,
  output logic stop_count_select,
  output logic [3:0] char_bits,
  output logic nine_bit_low_first,
  output logic nine_bit_high_first,
  output logic spi_bit_order,
  output logic spi_sample_phase,
  // Baud and auto-baud
  output logic [15:0] baud_divisor,
  output logic baud_reload,
  output ufb_pkg::ufb_rx_speed_t receiver_speed_select,
  output logic lin_sync_autobaud_mode,
  output logic [5:0] sync_gap_min,
  output logic [5:0] sync_gap_max,
  output logic [4:0] samples_per_bit,
  input wire logic sync_char_valid,
  input wire logic [7:0] sync_char,
  output logic sync_field_error_flag,
  // Transmit word stream
  output logic transmit_word_valid,
  input wire logic transmit_word_ready,
  output logic [8:0] transmit_word,
  // Receive word from the sampler
  input wire logic receive_word_valid,
  input wire logic [8:0] receive_word
);
  logic [7:0] frame_q;
  logic [7:0] ctrlb_q;
  logic [7:0] window_q;
  logic [15:0] baud_q;
  logic sync_err_q;
  logic [8:0] rx_word_q;
  logic [7:0] tx_part_q;
  logic tx_part_hi_q;
  logic [31:0] awaddr_q;
  logic aw_held_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic w_held_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  logic wr_go;
  logic [7:0] wr_idx;
  logic wr_map;
  logic [7:0] rd_idx;
  logic [7:0] wbyte;
  logic wr_low;
  logic push_valid;
  logic push_ready;
  logic [8:0] push_data;
  logic nine_bit;
  logic tx_hit;
  logic tx_last;
  logic [7:0] rd_byte;
  logic rd_map;
  logic [5:0] tol;

  // Write channels are taken independently; the response waits for both
  assign s_axi_awready = !aw_held_q && !bvalid_q;
  assign s_axi_wready = !w_held_q && !bvalid_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign wr_go = aw_held_q && w_held_q && !bvalid_q;
  assign wr_idx = awaddr_q[9:2];
  assign rd_idx = s_axi_araddr[9:2];
  assign wbyte = wdata_q[7:0];
  assign wr_low = wr_go && wr_map && wstrb_q[0];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      awaddr_q <= 32'h0000_0000;
      w_held_q <= 1'b0;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end else if (wr_go) begin
        aw_held_q <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end else if (wr_go) begin
        w_held_q <= 1'b0;
      end
    end
  end

  always_comb begin
    unique case (wr_idx)
      `UFB_IDX_TX_LOW, `UFB_IDX_TX_HIGH, `UFB_IDX_STATUS, `UFB_IDX_CTRLB,
      `UFB_IDX_FRAME, `UFB_IDX_BAUD_LOW, `UFB_IDX_BAUD_HIGH,
      `UFB_IDX_WINDOW: wr_map = (awaddr_q[31:10] == '0) && (awaddr_q[1:0] == 2'b00);
      default: wr_map = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q <= 2'b00;
    end else if (wr_go) begin
      bvalid_q <= 1'b1;
      bresp_q <= wr_map ? 2'b00 : 2'b10;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // Control registers; reserved codes are stored as written
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      frame_q <= `UFB_FRAME_RST; // R19
      ctrlb_q <= `UFB_CTRLB_RST;
      window_q <= `UFB_WINDOW_RST; // R19
    end else if (wr_low && wr_map) begin
      if (wr_idx == `UFB_IDX_FRAME) begin
        frame_q <= wbyte;
      end
      if (wr_idx == `UFB_IDX_CTRLB) begin
        ctrlb_q <= wbyte;
      end
      if (wr_idx == `UFB_IDX_WINDOW) begin
        window_q <= wbyte & 8'hc0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      baud_q <= `UFB_BAUD_RST; // R19
      baud_reload <= 1'b0;
    end else begin
      baud_reload <= wr_low && ((wr_idx == `UFB_IDX_BAUD_LOW) ||
                                (wr_idx == `UFB_IDX_BAUD_HIGH)); // R12
      if (wr_low && (wr_idx == `UFB_IDX_BAUD_LOW)) begin
        baud_q[7:0] <= wbyte; // R11
      end
      if (wr_low && (wr_idx == `UFB_IDX_BAUD_HIGH)) begin
        baud_q[15:8] <= wbyte; // R11
      end
    end
  end

  // Mode decode
  assign link_mode_select = ufb_pkg::ufb_link_mode_t'(frame_q[`UFB_MODE_HI:`UFB_MODE_LO]); // R2
  assign host_spi_mode = (link_mode_select == ufb_pkg::UFB_HOST_SPI); // R2
  assign infrared_mode = (link_mode_select == ufb_pkg::UFB_INFRARED); // R2
  assign multi_node_address_enable = ctrlb_q[`UFB_MULTI_NODE_ADDRESS_ENABLE_BIT]; // R1
  assign baud_divisor = baud_q;

  // Frame fields only mean parity, stop and width outside host SPI mode
  always_comb begin
    parity_select = ufb_pkg::UFB_PAR_NONE;
    stop_count_select = 1'b0;
    char_bits = 4'h8;
    spi_bit_order = 1'b0;
    spi_sample_phase = 1'b0;
    if (host_spi_mode) begin // R3
      spi_bit_order = frame_q[`UFB_ORDER_BIT]; // R8
      spi_sample_phase = frame_q[`UFB_PHASE_BIT]; // R10
    end else begin
      parity_select = ufb_pkg::ufb_parity_t'(frame_q[`UFB_PAR_HI:`UFB_PAR_LO]); // R4
      stop_count_select = frame_q[`UFB_STOP_BIT]; // R5
      unique case (ufb_pkg::ufb_char_size_t'(frame_q[`UFB_SIZE_HI:`UFB_SIZE_LO])) // R6
        ufb_pkg::UFB_CH5: char_bits = 4'h5;
        ufb_pkg::UFB_CH6: char_bits = 4'h6;
        ufb_pkg::UFB_CH7: char_bits = 4'h7;
        ufb_pkg::UFB_CH9_LOW, ufb_pkg::UFB_CH9_HIGH: char_bits = 4'h9;
        default: char_bits = 4'h8;
      endcase
    end
  end
  assign nine_bit = (char_bits == 4'h9);
  assign nine_bit_low_first = nine_bit && !frame_q[`UFB_SIZE_LO]; // R7
  assign nine_bit_high_first = nine_bit && frame_q[`UFB_SIZE_LO]; // R7

  // Auto-baud window
  assign receiver_speed_select = ufb_pkg::ufb_rx_speed_t'(ctrlb_q[`UFB_RXM_HI:`UFB_RXM_LO]);
  assign lin_sync_autobaud_mode = (receiver_speed_select == ufb_pkg::UFB_RX_LIN_AUTO); // R16
  always_comb begin
    unique case (window_q[`UFB_WIN_HI:`UFB_WIN_LO]) // R15
      2'b00: tol = `UFB_TOL_W0;
      2'b01: tol = `UFB_TOL_W1;
      2'b10: tol = `UFB_TOL_W2;
      2'b11: tol = `UFB_TOL_W3;
    endcase
  end
  assign sync_gap_min = `UFB_NOMINAL_GAP - tol; // R14
  assign sync_gap_max = `UFB_NOMINAL_GAP + tol; // R14
  assign samples_per_bit = `UFB_SAMPLES_PER_BIT; // R14

  // Sync error: a new event beats a write-one clear in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync_err_q <= 1'b0;
    end else if (lin_sync_autobaud_mode && sync_char_valid &&
                 (sync_char != `UFB_SYNC_CHAR)) begin
      sync_err_q <= 1'b1; // R17
    end else if (wr_low && (wr_idx == `UFB_IDX_STATUS) && wbyte[`UFB_SYNC_ERR_BIT]) begin
      sync_err_q <= 1'b0;
    end
  end
  assign sync_field_error_flag = sync_err_q;

  // Nine-bit words are pushed when the second byte of the pair lands
  assign tx_hit = wr_low && ((wr_idx == `UFB_IDX_TX_LOW) || (wr_idx == `UFB_IDX_TX_HIGH));
  assign tx_last = !nine_bit ? (wr_idx == `UFB_IDX_TX_LOW) :
                   nine_bit_low_first ? (wr_idx == `UFB_IDX_TX_HIGH) :
                   (wr_idx == `UFB_IDX_TX_LOW); // R7
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_part_q <= 8'h00;
      tx_part_hi_q <= 1'b0;
    end else if (tx_hit && !tx_last) begin
      tx_part_q <= wbyte;
      tx_part_hi_q <= wbyte[0];
    end
  end
  always_comb begin
    push_data = {1'b0, wbyte};
    if (nine_bit && nine_bit_low_first) begin
      push_data = {wbyte[0], tx_part_q};
    end else if (nine_bit) begin
      push_data = {tx_part_hi_q, wbyte};
    end
  end
  // A full FIFO drops the word; software watches the status fill bit
  assign push_valid = tx_hit && tx_last;

  ufb_fifo #(
    .WIDTH(9),
    .DEPTH(FIFO_DEPTH)
  ) u_tx_fifo (
    .aclk(aclk),
    .aresetn(aresetn),
    .in_valid(push_valid),
    .in_ready(push_ready),
    .in_data(push_data),
    .out_valid(transmit_word_valid),
    .out_ready(transmit_word_ready),
    .out_data(transmit_word)
  );

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_word_q <= 9'h000;
    end else if (receive_word_valid) begin
      rx_word_q <= receive_word;
    end
  end

  // Reads
  always_comb begin
    rd_byte = 8'h00;
    rd_map = (s_axi_araddr[31:10] == '0) && (s_axi_araddr[1:0] == 2'b00);
    unique case (rd_idx)
      `UFB_IDX_RX_LOW: rd_byte = rx_word_q[7:0];
      `UFB_IDX_RX_HIGH: rd_byte = {7'h00, rx_word_q[8]};
      `UFB_IDX_STATUS: rd_byte = {6'h00, !push_ready, sync_err_q};
      `UFB_IDX_CTRLB: rd_byte = ctrlb_q;
      `UFB_IDX_FRAME: rd_byte = host_spi_mode ? (frame_q & 8'hc6) : frame_q;
      `UFB_IDX_BAUD_LOW: rd_byte = baud_q[7:0];
      `UFB_IDX_BAUD_HIGH: rd_byte = baud_q[15:8];
      `UFB_IDX_WINDOW: rd_byte = window_q;
      default: rd_map = 1'b0;
    endcase
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= 2'b00;
    end else if (s_axi_arvalid && !rvalid_q) begin
      rvalid_q <= 1'b1;
      rdata_q <= {24'h000000, rd_map ? rd_byte : 8'h00};
      rresp_q <= rd_map ? 2'b00 : 2'b10;
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // Checks
  property p_multi_node_address_enable;
    @(posedge aclk) disable iff (!aresetn)
      (wr_low && wr_idx == `UFB_IDX_CTRLB)
      |=> multi_node_address_enable == $past(wbyte[`UFB_MULTI_NODE_ADDRESS_ENABLE_BIT]);
  endproperty
  a_multi_node_address_enable: assert property (p_multi_node_address_enable) else $error("multi-node enable mismatch"); // R1
  property p_spi_mode;
    @(posedge aclk) disable iff (!aresetn)
      host_spi_mode |-> (stop_count_select == 1'b0 && parity_select == ufb_pkg::UFB_PAR_NONE);
  endproperty
  a_spi_mode: assert property (p_spi_mode) else $error("frame fields live in spi mode"); // R3
  property p_frame_write;
    @(posedge aclk) disable iff (!aresetn)
      (wr_low && wr_map && wr_idx == `UFB_IDX_FRAME)
      |=> (frame_q == $past(wbyte) && link_mode_select == $past(wbyte[7:6]));
  endproperty
  a_frame_write: assert property (p_frame_write) else $error("frame write lost"); // R2
  property p_nine;
    @(posedge aclk) disable iff (!aresetn)
      (!host_spi_mode && frame_q[2:1] == 2'b11) |-> char_bits == 4'h9;
  endproperty
  a_nine: assert property (p_nine) else $error("nine-bit width wrong"); // R6
  sequence s_reload_pulse;
    baud_reload ##1 !baud_reload;
  endsequence
  property p_reload;
    @(posedge aclk) disable iff (!aresetn)
      (wr_low && wr_idx == `UFB_IDX_BAUD_HIGH) |=> s_reload_pulse;
  endproperty
  a_reload: assert property (p_reload) else $error("baud reload missing"); // R12
  property p_baud_hi;
    @(posedge aclk) disable iff (!aresetn)
      (wr_low && wr_idx == `UFB_IDX_BAUD_HIGH) |=> baud_divisor[15:8] == $past(wbyte);
  endproperty
  a_baud_hi: assert property (p_baud_hi) else $error("baud high byte lost"); // R11
  property p_window;
    @(posedge aclk) disable iff (!aresetn)
      (window_q[`UFB_WIN_HI:`UFB_WIN_LO] == 2'b11)
      |-> (sync_gap_min == 6'h18 && sync_gap_max == 6'h28);
  endproperty
  a_window: assert property (p_window) else $error("window not centred on 32"); // R15
  property p_sync_err;
    @(posedge aclk) disable iff (!aresetn)
      (wr_low && wr_idx == `UFB_IDX_STATUS && wbyte[`UFB_SYNC_ERR_BIT] && !sync_char_valid)
      |=> !sync_field_error_flag;
  endproperty
  a_sync_err: assert property (p_sync_err) else $error("sync error not cleared"); // R17
  property p_sync_set;
    @(posedge aclk) disable iff (!aresetn)
      (lin_sync_autobaud_mode && sync_char_valid && sync_char != 8'h55) |=> sync_err_q;
  endproperty
  a_sync_set: assert property (p_sync_set) else $error("sync error lost to clear"); // R17
endmodule

`default_nettype wire

// *** src/ufb_config_sva_note.sv ***
`timescale 1ns/1ps

// *** test/ufb_engine_model.sv ***
/*
  Behavioural model of the shifter and auto-baud engines that sit behind
  the configuration block: drains the transmit stream, sends sync and
  receive words on command. Assumes the bench seeds $urandom.
*/
`timescale 1ns/1ps
`default_nettype none

module ufb_engine_model (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Transmit stream
  input wire logic transmit_word_valid,
  output logic transmit_word_ready,
  input wire logic [8:0] transmit_word,
  // Auto-baud and receive
  output logic sync_char_valid,
  output logic [7:0] sync_char,
  output logic receive_word_valid,
  output logic [8:0] receive_word,
  // Bench control
  input wire logic stall
);
  logic [8:0] words[$];
  initial begin
    transmit_word_ready = 1'b0;
    sync_char_valid = 1'b0;
    sync_char = 8'h00;
    receive_word_valid = 1'b0;
    receive_word = 9'h000;
  end
  // Random ready so the drain side stalls at odd moments
  always @(posedge aclk) begin
    if (transmit_word_valid && transmit_word_ready)
      words.push_back(transmit_word);
    transmit_word_ready <= !stall && aresetn && ($urandom % 3 != 0);
  end
  task automatic send_sync(input logic [7:0] c);
    sync_char <= c;
    sync_char_valid <= 1'b1;
    @(posedge aclk);
    sync_char_valid <= 1'b0;
    // Stale data is inverted so it never passes for a fresh character
    sync_char <= ~c;
  endtask
  task automatic send_rx(input logic [8:0] w);
    receive_word <= w;
    receive_word_valid <= 1'b1;
    @(posedge aclk);
    receive_word_valid <= 1'b0;
    receive_word <= ~w;
  endtask
endmodule

`default_nettype wire

// *** test/tb.sv ***
/*
  Self-checking bench for the frame and baud configuration block.
  Assumes the engine model file and the design sources are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none

module tb;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
  logic [3:0] s_axi_wstrb, char_bits;
  logic [1:0] s_axi_bresp, s_axi_rresp, r, m, p;
  ufb_pkg::ufb_link_mode_t link_mode_select;
  ufb_pkg::ufb_parity_t parity_select;
  ufb_pkg::ufb_rx_speed_t receiver_speed_select;
  logic infrared_mode, host_spi_mode, multi_node_address_enable, stop_count_select;
  logic nine_bit_low_first, nine_bit_high_first, spi_bit_order, spi_sample_phase;
  logic baud_reload, lin_sync_autobaud_mode, sync_char_valid, sync_field_error_flag;
  logic transmit_word_valid, transmit_word_ready, receive_word_valid, stall;
  logic [15:0] baud_divisor, v;
  logic [5:0] sync_gap_min, sync_gap_max;
  logic [4:0] samples_per_bit;
  logic [7:0] sync_char, f, lo, hi;
  logic [8:0] transmit_word, receive_word;
  logic [8:0] exp_q[$];
  logic [31:0] d;
  logic [2:0] s;
  int err_total, samples_checked, reloads, n;
  // Reserved parity and width codes are never written
  logic [1:0] par_tab[3] = '{2'h0, 2'h2, 2'h3};
  logic [2:0] size_tab[6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h6, 3'h7};

  ufb_config #(.FIFO_DEPTH(16)) ufb_config_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .link_mode_select, .infrared_mode,
    .host_spi_mode, .multi_node_address_enable, .parity_select, .stop_count_select,
    .char_bits, .nine_bit_low_first, .nine_bit_high_first, .spi_bit_order, .spi_sample_phase,
    .baud_divisor, .baud_reload, .receiver_speed_select, .lin_sync_autobaud_mode,
    .sync_gap_min, .sync_gap_max, .samples_per_bit, .sync_char_valid, .sync_char,
    .sync_field_error_flag, .transmit_word_valid, .transmit_word_ready, .transmit_word,
    .receive_word_valid, .receive_word);
  ufb_engine_model ufb_engine_model_i (.aclk, .aresetn, .transmit_word_valid,
    .transmit_word_ready, .transmit_word, .sync_char_valid, .sync_char, .receive_word_valid,
    .receive_word, .stall);

  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    if (baud_reload === 1'b1)
      reloads++;
  end

  function automatic logic [3:0] exp_bits(input logic [2:0] c);
    return (c < 3'h4) ? 4'(c) + 4'h5 : ((c > 3'h5) ? 4'h9 : 4'h8);
  endfunction
  function automatic logic [5:0] tol(input logic [1:0] w);
    return (w == 2'h0) ? 6'h06 : (w == 2'h1) ? 6'h05 : (w == 2'h2) ? 6'h07 : 6'h08;
  endfunction

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] dat, output logic [1:0] rsp);
    logic a, w;
    a = 1'b0;
    w = 1'b0;
    s_axi_awaddr <= {22'h0, idx, 2'b00};
    s_axi_wdata <= {24'h0, dat};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!(a && w)) begin
      @(posedge aclk);
      if (!a && s_axi_awready === 1'b1) begin
        s_axi_awvalid <= 1'b0;
        a = 1'b1;
      end
      if (!w && s_axi_wready === 1'b1) begin
        s_axi_wvalid <= 1'b0;
        w = 1'b1;
      end
    end
    s_axi_bready <= 1'b1;
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] idx, output logic [31:0] dat, output logic [1:0] rsp);
    s_axi_araddr <= {22'h0, idx, 2'b00};
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    dat = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic rdchk(input logic [7:0] idx, input logic [31:0] e, input string nm);
    logic [31:0] x;
    logic [1:0] y;
    rd(idx, x, y);
    chk(nm, e, x);
  endtask
  task automatic tdone(input string nm);
    $display("test %s finished", nm);
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // Whole run needs under four hundred cycles
  initial begin
    repeat (20000) @(posedge aclk);
    err_total++;
    conclude();
  end

  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h00;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = 96'h0;
    s_axi_wstrb = 4'hf;
    stall = 1'b1;
    n = $urandom(23059);
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rdchk(8'h07, 32'h03, "frame_rst");
    rdchk(8'h08, 32'h00, "baud_rst");
    rdchk(8'h0a, 32'h00, "window_rst");
    chk("char_bits_rst", 4'h8, char_bits);
    chk("gap_min_rst", 6'h1a, sync_gap_min);
    chk("samples_per_bit", 5'h10, samples_per_bit);
    tdone("reset");
    // Bit order only changes with the stream idle
    for (int i = 0; i < 24; i++) begin
      m = 2'(i % 4);
      p = par_tab[i % 3];
      s = size_tab[i % 6];
      f = {m, p, 1'($urandom), s};
      if (m == 2'h3)
        f[2:1] = 2'($urandom);
      wr(8'h07, f, r);
      chk("link_mode", m, link_mode_select);
      chk("infrared", m == 2'h2, infrared_mode);
      chk("host_spi", m == 2'h3, host_spi_mode);
      if (m != 2'h3) begin
        chk("parity", p, parity_select);
        chk("stop", f[3], stop_count_select);
        chk("char_bits", exp_bits(s), char_bits);
        chk("low_first", s == 3'h6, nine_bit_low_first);
        chk("high_first", s == 3'h7, nine_bit_high_first);
        chk("order_off", 1'b0, spi_bit_order);
        rdchk(8'h07, f, "frame");
      end else begin
        chk("spi_order", f[2], spi_bit_order);
        chk("spi_phase", f[1], spi_sample_phase);
        chk("spi_parity", 2'h0, parity_select);
        rdchk(8'h07, f & 8'hc6, "spi_frame");
      end
    end
    tdone("frame");
    for (int b = 0; b < 8; b++) begin
      wr(8'h06, 8'(b), r);
      chk("multi_node", b[0], multi_node_address_enable);
      chk("rx_speed", b[2:1], receiver_speed_select);
      chk("lin_auto", b[2:1] == 2'h3, lin_sync_autobaud_mode);
    end
    for (int w = 0; w < 4; w++) begin
      wr(8'h0a, {2'(w), 6'($urandom)}, r);
      chk("gap_min", 6'h20 - tol(2'(w)), sync_gap_min);
      chk("gap_max", 6'h20 + tol(2'(w)), sync_gap_max);
      rdchk(8'h0a, {24'h0, 2'(w), 6'h00}, "window");
    end
    tdone("ctrl_window");
    // Divisor changes only while nothing is shifting
    repeat (3) begin
      v = 16'($urandom);
      n = reloads;
      wr(8'h08, v[7:0], r);
      wr(8'h09, v[15:8], r);
      @(posedge aclk);
      chk("baud", v, baud_divisor);
      chk("reloads", 2, reloads - n);
      rdchk(8'h09, v[15:8], "baud_high");
    end
    tdone("baud");
    wr(8'h06, 8'h06, r);
    ufb_engine_model_i.send_sync(8'h55);
    repeat (2) @(posedge aclk);
    chk("sync_ok", 1'b0, sync_field_error_flag);
    ufb_engine_model_i.send_sync(8'h2a);
    repeat (2) @(posedge aclk);
    chk("sync_bad", 1'b1, sync_field_error_flag);
    rdchk(8'h04, 32'h1, "status");
    wr(8'h04, 8'h01, r);
    chk("sync_clear", 1'b0, sync_field_error_flag);
    wr(8'h06, 8'h00, r);
    ufb_engine_model_i.send_sync(8'h2a);
    @(posedge aclk);
    chk("sync_off", 1'b0, sync_field_error_flag);
    ufb_engine_model_i.send_rx(9'h1a5);
    @(posedge aclk);
    rdchk(8'h00, 32'ha5, "rx_low");
    rdchk(8'h01, 32'h01, "rx_high");
    rd(8'h05, d, r);
    chk("unmapped_rresp", 2'b10, r);
    chk("unmapped_rdata", 0, d);
    wr(8'h3f, 8'h11, r);
    chk("unmapped_bresp", 2'b10, r);
    tdone("sync_rx_unmapped");
    wr(8'h07, 8'h03, r);
    for (int i = 0; i < 17; i++) begin
      lo = 8'($urandom);
      wr(8'h02, lo, r);
      if (i < 16)
        exp_q.push_back({1'b0, lo});
    end
    rdchk(8'h04, 32'h2, "fifo_full");
    stall <= 1'b0;
    while (ufb_engine_model_i.words.size() < 16) @(posedge aclk);
    for (int c = 6; c < 8; c++) begin
      lo = 8'($urandom);
      hi = 8'($urandom);
      wr(8'h07, 8'(c), r);
      wr((c == 6) ? 8'h02 : 8'h03, (c == 6) ? lo : hi, r);
      wr((c == 6) ? 8'h03 : 8'h02, (c == 6) ? hi : lo, r);
      exp_q.push_back({hi[0], lo});
    end
    while (ufb_engine_model_i.words.size() < 18) @(posedge aclk);
    for (int i = 0; i < 18; i++)
      chk("tx_word", exp_q[i], ufb_engine_model_i.words[i]);
    tdone("fifo");
    conclude();
  end
endmodule

`default_nettype wire
